// [rmdc_top.sv]
`timescale 1ns/1ns
// Summary of operation
// - all switches off opens the menu at 115200 8N1
// - switches decode into five line modes: RS422, auto and RTS RS485
// - off off on on applies the stored configuration
// - fourth switch enables termination in switch modes; stored configuration uses its stored setting only
// - RS422 keeps the transmitter always on, 4-wire full duplex
// - RS485 modes never echo own transmit data to the host
// - RS485 transmitter enable comes from RTS or auto direction logic
// - auto direction measures bit rate live, 300 bps to 250 kbps
// - RTS control supports rates up to 1 Mbps
// - 2-wire half duplex exists only in RS485 modes
// - host side is DCE: drives RxD, takes TxD and RTS
// - indicator shows when auto direction logic enables the transmitter
// - activity indicators for data from and to the host
// - activity indicators for bus transmit and bus receive
// - a start bit on outgoing data enables the transmitter
// - switch off after 11, 6 or 2 idle bit times
// - RTS active enables transmitter, inactive disables it
module rmdc_top #(
    parameter int SW_DEB_N      = rmdc_pkg::SW_DEB_CYC,
    parameter int ART_BIT_MAX_N = rmdc_pkg::ART_BIT_MAX_CYC
) (
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_i,
    // configuration
    input  wire rmdc_pkg::rmdc_switch_type   cfg_switch_i,
    input  wire rmdc_pkg::rmdc_line_cfg_type nv_cfg_i,
    // host side (dce)
    input  wire logic                       host_txd_i,
    input  wire logic                       host_rts_i,
    output logic                            host_rxd_o,
    // bus side
    input  wire logic                       bus_rx_i,
    output logic                            bus_txd_o,
    output logic                            bus_tx_en_o,
    output logic                            term_en_o,
    output logic                            half_duplex_o,
    // menu and status
    output logic                            menu_active_o,
    output logic [11:0]                     menu_baud_div_o,
    output rmdc_pkg::rmdc_mode_type          mode_o,
    output rmdc_pkg::rmdc_led_type           led_o
);
    import rmdc_pkg::*;

    rmdc_switch_type       sw_db;
    logic                  rts_db;
    rmdc_state_type        st_reg;
    rmdc_state_type        st_next;
    logic [3:0]            sw_code;
    logic [3:0]            dly_bits;
    logic [IDLE_CNT_W-1:0] thresh;
    logic                  is_art;
    logic                  is_485;

    // ----------------------------------------------------------------
    // input filtering
    // ----------------------------------------------------------------
    rmdc_sync_deb #(
        .W        (4),
        .CNT_W    (SW_DEB_W),
        .STABLE_N (SW_DEB_N)
    ) u_sw_deb (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .raw_i      (cfg_switch_i),
        .level_o    (sw_db)
    );

    // short filter keeps 1 Mbps timing
    rmdc_sync_deb #(
        .W        (1),
        .CNT_W    (RTS_DEB_W),
        .STABLE_N (RTS_DEB_CYC)
    ) u_rts_deb (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .raw_i      (host_rts_i),
        .level_o    (rts_db)
    );

    assign sw_code = {sw_db.cfg_switch_1, sw_db.cfg_switch_2, sw_db.cfg_switch_3, sw_db.cfg_switch_4};
    assign is_art  = (st_reg.cfg.kind == KIND_ART);
    assign is_485  = is_art || (st_reg.cfg.kind == KIND_RTS);

    always_comb begin
        case (st_reg.cfg.dly)
            DLY_SEL_MED:   dly_bits = DLY_MED_BITS;
            DLY_SEL_SHORT: dly_bits = DLY_SHORT_BITS;
            default:       dly_bits = DLY_LONG_BITS;
        endcase
    end

    assign thresh = IDLE_CNT_W'(st_reg.bit_len) * IDLE_CNT_W'(dly_bits);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next             = st_reg;
        st_next.menu_active = 1'h0;
        st_next.cfg         = CFG_OFF;
        case (sw_code)
            SW_MENU: begin
                st_next.mode        = MODE_MENU;
                st_next.menu_active = 1'h1;
            end
            SW_FACTORY: begin
                st_next.mode = MODE_FACTORY;
                st_next.cfg  = FACTORY_CFG;
            end
            SW_SOFT: begin
                st_next.mode = MODE_SOFT;
                st_next.cfg  = nv_cfg_i;
                if (nv_cfg_i.kind == KIND_RS422 || nv_cfg_i.kind == KIND_OFF) begin
                    st_next.cfg.two_wire = 1'h0;
                end
            end
            default: begin
                st_next.mode = MODE_SWITCH;
                st_next.cfg.term = sw_db.cfg_switch_4;
                case (sw_code[3:1])
                    SW_RS422_4W: st_next.cfg.kind = KIND_RS422;
                    SW_ART_4W:   st_next.cfg.kind = KIND_ART;
                    SW_RTS_4W:   st_next.cfg.kind = KIND_RTS;
                    SW_ART_2W: begin
                        st_next.cfg.kind     = KIND_ART;
                        st_next.cfg.two_wire = 1'h1;
                    end
                    SW_RTS_2W: begin
                        st_next.cfg.kind     = KIND_RTS;
                        st_next.cfg.two_wire = 1'h1;
                    end
                    default: begin
                        st_next.mode     = MODE_INVALID;
                        st_next.cfg.term = 1'h0;
                    end
                endcase
            end
        endcase
        st_next.menu_div = st_next.menu_active ? MENU_BAUD_DIV : 12'h000;

        // auto direction: start bit on, idle bit times off
        st_next.txd_d = host_txd_i;
        if (!is_art) begin
            st_next.art_en   = 1'h0;
            st_next.idle_cnt = '0;
            st_next.run_cnt  = '0;
        end else if (!host_txd_i) begin
            st_next.art_en   = 1'h1;
            st_next.idle_cnt = '0;
            if (!st_reg.art_en) begin
                st_next.bit_len = BIT_CNT_W'(ART_BIT_MAX_N);
                st_next.run_cnt = BIT_CNT_W'(1);
            end else if (st_reg.run_cnt < BIT_CNT_W'(ART_BIT_MAX_N)) begin
                st_next.run_cnt = st_reg.run_cnt + BIT_CNT_W'(1);
            end
        end else begin
            st_next.run_cnt = '0;
            // shortest low run is one bit time
            if (!st_reg.txd_d && st_reg.art_en && st_reg.run_cnt < st_reg.bit_len) begin
                st_next.bit_len = (st_reg.run_cnt < BIT_CNT_W'(ART_BIT_MIN_CYC)) ?
                                  BIT_CNT_W'(ART_BIT_MIN_CYC) : st_reg.run_cnt;
            end
            if (st_reg.art_en) begin
                if (st_reg.idle_cnt >= thresh) begin
                    st_next.art_en   = 1'h0;
                    st_next.idle_cnt = '0;
                end else begin
                    st_next.idle_cnt = st_reg.idle_cnt + IDLE_CNT_W'(1);
                end
            end
        end

        case (st_reg.cfg.kind)
            KIND_RS422: st_next.tx_en = 1'h1;
            KIND_ART:   st_next.tx_en = st_next.art_en;
            KIND_RTS:   st_next.tx_en = rts_db;
            default:    st_next.tx_en = 1'h0;
        endcase

        st_next.bus_txd = host_txd_i;
        if (st_reg.cfg.kind == KIND_OFF) begin
            st_next.host_rxd = 1'h1;
        end else if (is_485 && st_next.tx_en) begin
            st_next.host_rxd = 1'h1;
        end else begin
            st_next.host_rxd = bus_rx_i;
        end

        st_next.led.tx_enable_indicator  = is_art && st_next.art_en;
        st_next.led.host_rx_activity_led = !host_txd_i;
        st_next.led.host_tx_activity_led = !st_next.host_rxd;
        st_next.led.bus_tx_activity_led  = !host_txd_i && st_next.tx_en;
        st_next.led.bus_rx_activity_led  = !bus_rx_i && !(is_485 && st_next.tx_en);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_reg <= '{cfg: CFG_OFF, mode: MODE_INVALID, menu_active: 1'h0, menu_div: 12'h000,
                        art_en: 1'h0, run_cnt: '0, bit_len: '0, idle_cnt: '0, txd_d: 1'h1,
                        tx_en: 1'h0, bus_txd: 1'h1, host_rxd: 1'h1, led: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign host_rxd_o      = st_reg.host_rxd;
    assign bus_txd_o       = st_reg.bus_txd;
    assign bus_tx_en_o     = st_reg.tx_en;
    assign term_en_o       = st_reg.cfg.term;
    assign half_duplex_o   = st_reg.cfg.two_wire;
    assign menu_active_o   = st_reg.menu_active;
    assign menu_baud_div_o = st_reg.menu_div;
    assign mode_o          = st_reg.mode;
    assign led_o           = st_reg.led;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_art_idle_done;
        is_art && st_reg.art_en && host_txd_i && (st_reg.idle_cnt >= thresh);
    endsequence

    sequence s_art_idle_wait;
        is_art && st_reg.art_en && host_txd_i && (st_reg.idle_cnt < thresh);
    endsequence

    a_menu_open: assert property (sw_code == SW_MENU |=> menu_active_o && menu_baud_div_o == MENU_BAUD_DIV)
        else $error("menu not opened with all switches off");
    a_art_2w_decode: assert property (sw_code == 4'hC |=> half_duplex_o && st_reg.cfg.kind == KIND_ART)
        else $error("auto 2-wire switch code decoded wrongly");
    a_soft_cfg_used: assert property (sw_code == SW_SOFT && nv_cfg_i.kind == KIND_RTS |=> st_reg.cfg == $past(nv_cfg_i))
        else $error("stored configuration not applied");
    a_term_switch: assert property (sw_code[3:1] == SW_RS422_4W |=> term_en_o == $past(sw_db.cfg_switch_4))
        else $error("termination does not follow fourth switch");
    a_rs422_tx_on: assert property (st_reg.cfg.kind == KIND_RS422 |=> bus_tx_en_o)
        else $error("RS422 transmitter not enabled");
    a_no_echo: assert property (bus_tx_en_o && $past(is_485) |-> host_rxd_o)
        else $error("own transmit data echoed to host");
    a_rts_follow: assert property (st_reg.cfg.kind == KIND_RTS |=> bus_tx_en_o == $past(rts_db))
        else $error("transmitter enable does not follow RTS");
    a_art_start: assert property (is_art && !host_txd_i |=> bus_tx_en_o [*1] ##0 led_o.tx_enable_indicator)
        else $error("start bit did not enable transmitter");
    a_art_release: assert property (s_art_idle_done |=> !bus_tx_en_o)
        else $error("transmitter not released after idle time");
    a_art_hold: assert property (s_art_idle_wait |=> bus_tx_en_o)
        else $error("transmitter released too early");
    a_bit_len_floor: assert property (is_art && st_reg.art_en && $past(st_reg.art_en) |-> st_reg.bit_len >= BIT_CNT_W'(ART_BIT_MIN_CYC))
        else $error("measured bit time below fastest rate");
    a_half_duplex_485: assert property (half_duplex_o |-> is_485)
        else $error("2-wire set outside RS485");
    a_host_led: assert property (!host_txd_i |=> led_o.host_rx_activity_led)
        else $error("host receive activity not shown");

endmodule : rmdc_top

// [rmdc_pkg.sv]
package rmdc_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ          = 250_000_000;
    localparam int          MENU_BAUD       = 115_200;
    localparam logic [11:0] MENU_BAUD_DIV   = 12'(CLK_HZ / MENU_BAUD);
    localparam int          ART_MIN_BPS     = 300;
    localparam int          ART_MAX_BPS     = 250_000;
    localparam int          ART_BIT_MAX_CYC = CLK_HZ / ART_MIN_BPS;
    localparam int          ART_BIT_MIN_CYC = CLK_HZ / ART_MAX_BPS;
    localparam int          SW_DEB_MS       = 10;
    localparam int          SW_DEB_CYC      = (CLK_HZ / 1000) * SW_DEB_MS;
    localparam int          SW_DEB_W        = 22;
    // rts must follow 1 Mbps framing, so only a short filter
    localparam int          RTS_DEB_CYC     = 2;
    localparam int          RTS_DEB_W       = 2;
    localparam int          BIT_CNT_W       = 20;
    localparam int          IDLE_CNT_W      = 24;

    // ----------------------------------------------------------------
    // switch off delay in bit times
    // ----------------------------------------------------------------
    localparam logic [1:0]  DLY_SEL_LONG    = 2'h0;
    localparam logic [1:0]  DLY_SEL_MED     = 2'h1;
    localparam logic [1:0]  DLY_SEL_SHORT   = 2'h2;
    localparam logic [3:0]  DLY_LONG_BITS   = 4'hB;
    localparam logic [3:0]  DLY_MED_BITS    = 4'h6;
    localparam logic [3:0]  DLY_SHORT_BITS  = 4'h2;

    // ----------------------------------------------------------------
    // line kinds and switch codes (s1 s2 s3 s4, on = 1)
    // ----------------------------------------------------------------
    localparam logic [1:0]  KIND_OFF        = 2'h0;
    localparam logic [1:0]  KIND_RS422      = 2'h1;
    localparam logic [1:0]  KIND_ART        = 2'h2;
    localparam logic [1:0]  KIND_RTS        = 2'h3;
    localparam logic [3:0]  SW_MENU         = 4'h0;
    localparam logic [3:0]  SW_FACTORY      = 4'h1;
    localparam logic [3:0]  SW_SOFT         = 4'h3;
    localparam logic [2:0]  SW_RS422_4W     = 3'h5;
    localparam logic [2:0]  SW_ART_4W       = 3'h7;
    localparam logic [2:0]  SW_ART_2W       = 3'h6;
    localparam logic [2:0]  SW_RTS_4W       = 3'h3;
    localparam logic [2:0]  SW_RTS_2W       = 3'h2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cfg_switch_1;
        logic cfg_switch_2;
        logic cfg_switch_3;
        logic cfg_switch_4;
    } rmdc_switch_type;

    typedef struct packed {
        logic [1:0] kind;
        logic       two_wire;
        logic       term;
        logic [1:0] dly;
    } rmdc_line_cfg_type;

    typedef struct packed {
        logic host_rx_activity_led;
        logic host_tx_activity_led;
        logic bus_tx_activity_led;
        logic bus_rx_activity_led;
        logic tx_enable_indicator;
    } rmdc_led_type;

    typedef enum logic [4:0] {
        MODE_MENU    = 5'h01,
        MODE_FACTORY = 5'h02,
        MODE_SOFT    = 5'h04,
        MODE_SWITCH  = 5'h08,
        MODE_INVALID = 5'h10
    } rmdc_mode_type;

    typedef struct packed {
        rmdc_line_cfg_type     cfg;
        rmdc_mode_type         mode;
        logic                  menu_active;
        logic [11:0]           menu_div;
        logic                  art_en;
        logic [BIT_CNT_W-1:0]  run_cnt;
        logic [BIT_CNT_W-1:0]  bit_len;
        logic [IDLE_CNT_W-1:0] idle_cnt;
        logic                  txd_d;
        logic                  tx_en;
        logic                  bus_txd;
        logic                  host_rxd;
        rmdc_led_type          led;
    } rmdc_state_type;

    localparam rmdc_line_cfg_type CFG_OFF     = '{kind: KIND_OFF, two_wire: 1'h0, term: 1'h0, dly: DLY_SEL_LONG};
    localparam rmdc_line_cfg_type FACTORY_CFG = '{kind: KIND_ART, two_wire: 1'h0, term: 1'h1, dly: DLY_SEL_LONG};

endpackage : rmdc_pkg

// [rmdc_sync_deb.sv]
`timescale 1ns/1ns
module rmdc_sync_deb #(
    parameter int W        = 1,
    parameter int CNT_W    = 2,
    parameter int STABLE_N = 2
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    // raw and filtered levels
    input  wire logic [W-1:0] raw_i,
    output logic      [W-1:0] level_o
);
    import rmdc_pkg::*;

    typedef struct packed {
        logic [W-1:0]     sync1;
        logic [W-1:0]     sync2;
        logic [W-1:0]     level;
        logic [CNT_W-1:0] cnt;
    } rmdc_deb_state_type;

    rmdc_deb_state_type st_reg;
    rmdc_deb_state_type st_next;

    // ----------------------------------------------------------------
    // two flop synchroniser, then hold until stable
    // ----------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = raw_i;
        st_next.sync2 = st_reg.sync1;
        if (st_reg.sync2 != st_reg.level) begin
            if (st_reg.cnt >= CNT_W'(STABLE_N - 1)) begin
                st_next.level = st_reg.sync2;
                st_next.cnt   = '0;
            end else begin
                st_next.cnt = st_reg.cnt + CNT_W'(1);
            end
        end else begin
            st_next.cnt = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.level;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    a_deb_level_held: assert property ($changed(level_o) |-> $past(st_reg.cnt) == CNT_W'(STABLE_N - 1))
        else $error("filtered level changed before the stable count");

endmodule : rmdc_sync_deb

// [rmdc_far_model.sv]
`timescale 1ns/1ns
module rmdc_far_model (
    // converter bus side
    input  wire logic bus_txd_i,
    input  wire logic bus_tx_en_i,
    input  wire logic half_duplex_i,
    // remote station
    input  wire logic stn_drive_i,
    input  wire logic stn_bit_i,
    // line receiver output
    output logic      bus_rx_o
);
    // ----------------------------------------------------------------
    // line level
    // ----------------------------------------------------------------
    // pair shared in two wire
    always_comb begin
        if (half_duplex_i && bus_tx_en_i) begin
            bus_rx_o = bus_txd_i;
        end else if (stn_drive_i) begin
            bus_rx_o = stn_bit_i;
        end else begin
            // bias pulls a released line to mark
            bus_rx_o = 1'b1;
        end
    end
endmodule : rmdc_far_model

// [rmdc_test.sv]
`timescale 1ns/1ns
module rmdc_test;
    import rmdc_pkg::*;
    logic              core_clk_i;
    logic              reset_i;
    rmdc_switch_type   sw;
    rmdc_line_cfg_type nv;
    logic              txd, rts, stn_drive, stn_bit, bus_rx, exp_txd, run;
    logic              host_rxd, bus_txd, tx_en, term_en, half_dup, menu;
    logic [11:0]       div;
    rmdc_mode_type     mode;
    rmdc_led_type      led;
    logic [31:0]       seed;
    int                n_fail, check_count, k, len, bits;

    rmdc_top #(.SW_DEB_N(4), .ART_BIT_MAX_N(5000)) dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .cfg_switch_i(sw), .nv_cfg_i(nv),
        .host_txd_i(txd), .host_rts_i(rts), .host_rxd_o(host_rxd), .bus_rx_i(bus_rx),
        .bus_txd_o(bus_txd), .bus_tx_en_o(tx_en), .term_en_o(term_en), .half_duplex_o(half_dup),
        .menu_active_o(menu), .menu_baud_div_o(div), .mode_o(mode), .led_o(led));
    rmdc_far_model far (
        .bus_txd_i(bus_txd), .bus_tx_en_i(tx_en), .half_duplex_i(half_dup),
        .stn_drive_i(stn_drive), .stn_bit_i(stn_bit), .bus_rx_o(bus_rx));

    // ----------------------------------------------------------------
    // helpers and reference model
    // ----------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction : nxt

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask : settle

    // line kind: 0 none, 1 rs422, 2 auto, 3 rts
    function automatic int exp_kind(input int c, input rmdc_line_cfg_type n);
        case (c >> 1)
            5: return 1;
            6, 7: return 2;
            2, 3: return 3;
            default: return (c == 1) ? 2 : (c == 3) ? int'(n.kind) : 0;
        endcase
    endfunction : exp_kind

    function automatic logic [4:0] exp_mode(input int c);
        if (c == 0) return 5'h01;
        if (c == 1) return 5'h02;
        if (c == 3) return 5'h04;
        if ((c >> 1) inside {2, 3, 5, 6, 7}) return 5'h08;
        return 5'h10;
    endfunction : exp_mode

    always @(posedge core_clk_i) exp_txd <= txd;
    always @(negedge core_clk_i) begin
        if (run) begin
            check(bus_txd, exp_txd, "bus txd");
            check(led.host_rx_activity_led, !exp_txd, "host rx led");
        end
    end

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (100000) @(posedge core_clk_i);
        n_fail++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_i = 1'b1; sw = '0; nv = '0; txd = 1'b1; rts = 1'b0;
        stn_drive = 1'b1; stn_bit = 1'b0; run = 1'b0; n_fail = 0; check_count = 0;
        seed = 32'h8db3;
        settle(4);
        check(mode, 5'h10, "reset mode");
        check({tx_en, host_rxd, led}, 7'h20, "reset outputs");
        @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        run <= 1'b1;
        // every switch code, station holding a space on the line
        for (int c = 0; c < 16; c++) begin
            seed = nxt(seed);
            @(posedge core_clk_i);
            sw <= rmdc_switch_type'(c[3:0]);
            nv <= '{kind: seed[1:0], two_wire: seed[2], term: seed[3], dly: 2'h0};
            settle(12);
            k = exp_kind(c, nv);
            check(mode, exp_mode(c), "mode");
            check(menu, c == 0, "menu");
            check(div, (c == 0) ? MENU_BAUD_DIV : 12'h0, "baud div");
            if (exp_mode(c) inside {5'h02, 5'h04, 5'h08}) begin
                check(term_en, (c == 1) ? 1'b1 : (c == 3) ? nv.term : c[0], "term");
                check(half_dup, (c == 3) ? (nv.two_wire && k >= 2) : ((c >> 1) inside {2, 6}), "2w");
            end
            check(tx_en, k == 1, "driver");
            check(host_rxd, k == 0, "host rxd");
            check(led.bus_rx_activity_led, 1'b1, "bus rx led");
            check(led.host_tx_activity_led, k != 0, "host tx led");
        end
        // short bounce to menu code is ignored
        @(posedge core_clk_i);
        sw <= '0;
        repeat (2) @(posedge core_clk_i);
        sw <= 4'hF;
        settle(12);
        check(mode, 5'h08, "bounce");
        // rts controlled four wire
        @(posedge core_clk_i);
        sw <= 4'h6;
        repeat (12) @(posedge core_clk_i);
        rts <= 1'b1;
        settle(3);
        check(tx_en, 1'b0, "rts early");
        settle(3);
        check(tx_en, 1'b1, "rts on");
        check(host_rxd, 1'b1, "no echo");
        check(led.tx_enable_indicator, 1'b0, "rts ind");
        @(posedge core_clk_i);
        rts <= 1'b0;
        settle(7);
        check(tx_en, 1'b0, "rts off");
        // auto direction, stored config, each switch off delay
        for (int d = 0; d < 3; d++) begin
            seed = nxt(seed);
            @(posedge core_clk_i);
            sw <= 4'h3;
            nv <= '{kind: KIND_ART, two_wire: d[0], term: 1'b1, dly: d[1:0]};
            stn_drive <= 1'b0;
            len = 1000 + int'(seed % 400);
            bits = (d == 0) ? 11 : (d == 1) ? 6 : 2;
            repeat (12) @(posedge core_clk_i);
            txd <= 1'b0;
            settle(1);
            check(tx_en, 1'b1, "start bit");
            check(led.tx_enable_indicator, 1'b1, "auto ind");
            check(led.bus_tx_activity_led, 1'b1, "bus tx led");
            check(host_rxd, 1'b1, "auto no echo");
            repeat (len - 1) @(posedge core_clk_i);
            txd <= 1'b1;
            settle(len * bits);
            check(tx_en, 1'b1, "hold");
            settle(1);
            check(tx_en, 1'b0, "release");
            check(led.tx_enable_indicator, 1'b0, "ind off");
        end
        end_of_test();
    end
endmodule : rmdc_test
